/* rtl/sdram_mode_pkg.sv */
// shared constants for the gear-down / power-save link
// assumes one clock clk_sys (250 MHz) and synchronous active-high reset
package sdram_mode_pkg;
  // --------------------------------------------------
  // command codes on the link
  // --------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP, CMD_MRS_GEAR, CMD_MRS_MPS, CMD_REF,
    CMD_SRE, CMD_SRX,      CMD_ACT,     CMD_RD
  } cmd_type;
  localparam int CNT_W = 16;
  // --------------------------------------------------
  // delays in clock cycles, tune here
  // --------------------------------------------------
  localparam logic [CNT_W-1:0] SYNC_GEAR_CYC = 16'h0008; // must be even
  localparam logic [CNT_W-1:0] CMD_GEAR_CYC  = 16'h0008;
  localparam logic [CNT_W-1:0] DLLK_CYC      = 16'h0300;
  localparam logic [CNT_W-1:0] XS_CYC        = 16'h0040;
  localparam logic [CNT_W-1:0] XSDLL_CYC     = 16'h0300;
  localparam logic [CNT_W-1:0] MPED_CYC      = 16'h0010;
  localparam logic [CNT_W-1:0] CKMPE_CYC     = 16'h0010;
  localparam logic [CNT_W-1:0] CKMPX_CYC     = 16'h0010;
  localparam logic [CNT_W-1:0] MPX_LH_CYC    = 16'h0004;
  localparam logic [CNT_W-1:0] XMP_CYC       = 16'h0020;
  localparam logic [CNT_W-1:0] XMP_DLL_CYC   = 16'h0300;
  localparam logic [CNT_W-1:0] RST_HOLD_CYC  = 16'h0010;
  localparam logic [CNT_W-1:0] CNT_ZERO      = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE       = 16'h0001;
  // --------------------------------------------------
  // controller register map (word addresses on a 4-bit port)
  // --------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_LAT    = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  // control bits, write-one pulses
  localparam int CB_GEAR = 0;
  localparam int CB_SRE  = 1;
  localparam int CB_SRX  = 2;
  localparam int CB_SRXG = 3;
  localparam int CB_MPSE = 4;
  localparam int CB_MPSX = 5;
  localparam int CB_CMD  = 6;
  localparam int CB_DLL  = 7;
  // latency register fields
  localparam int LB_CL    = 0;  // [4:0]
  localparam int LB_CWL   = 8;  // [12:8]
  localparam int LB_ALBAD = 16; // additive latency other than off or CL-2
  localparam int LB_CAL   = 17;
  localparam int LB_PAR   = 18;
  localparam logic [18:0] LAT_RESET = 19'h00000;
  // speed grade supports quarter rate (2666 or faster)
  localparam logic SPEED_GEAR_OK = 1'b1;
endpackage

/* rtl/sdram_mode_if.sv */
// link between memory controller end and device end
// assumes both ends share clk_sys; the link has no tristate pins
interface sdram_mode_if;
  import sdram_mode_pkg::*;
  logic    resetN; // device reset, low active
  logic    cke;    // clock enable
  logic    csN;    // chip select, low active
  logic    ckEn;   // controller keeps the memory clock valid
  cmd_type cmd;    // command code, valid when csN low
  modport ctrl (output resetN, output cke, output csN, output ckEn, output cmd);
  modport dev  (input resetN, input cke, input csN, input ckEn, input cmd);
endinterface

/* rtl/sdram_mode_dev.sv */
// device end: gear-down and maximum power-saving mode tracking
// assumes commands synchronous to clk_sys, one command per cs low cycle
module sdram_mode_dev
  import sdram_mode_pkg::*;
(
  input  wire logic   clk_sys,    // system clock
  input  wire logic   sys_rst,    // sync reset, high
  sdram_mode_if.dev   link,       // command link
  output logic        gear2n,     // quarter-rate capture active
  output logic        maxPower,   // in maximum power-saving mode
  output logic        selfRef,    // in self refresh
  output logic        readyNoDll, // commands without DLL accepted
  output logic        readyDll,   // commands needing DLL accepted
  output logic        cmdTaken,   // pulse: command accepted
  output logic        protoErr    // pulse: illegal command seen
);
  // --------------------------------------------------
  // state
  // --------------------------------------------------
  typedef enum logic [2:0] {
    D_RUN, D_SYNC, D_SETTLE, D_SR, D_SRX, D_MPENT, D_MP, D_MPEXIT
  } dstate_type;
  typedef struct packed {
    dstate_type        st;
    logic [CNT_W-1:0]  cnt;     // phase counter
    logic [CNT_W-1:0]  dllCnt;  // cycles until DLL usable
    logic              window;  // gear entry allowed
    logic              ckePrev; // cke last cycle, for rising edge
    logic              gear2n;
    logic              taken;
    logic              err;
  } dev_type;
  dev_type cur;      // registered state
  dev_type next_cur; // next state
  logic    valid;    // command qualified by cs
  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.taken = 1'b0;
    next_cur.err = 1'b0;
    next_cur.ckePrev = link.cke;
    valid = link.cke && !link.csN;
    if (cur.dllCnt != CNT_ZERO) begin
      next_cur.dllCnt = cur.dllCnt - CNT_ONE;
    end
    case (cur.st)
      D_RUN: begin
        if (valid) begin
          next_cur.taken = 1'b1;
          case (link.cmd)
            CMD_MRS_GEAR: begin
              // entry only at init or after self refresh exit
              if (cur.window && !cur.gear2n) begin
                next_cur.st = D_SYNC;
                next_cur.cnt = CNT_ONE;
              end else begin
                next_cur.taken = 1'b0;
                next_cur.err = 1'b1;
              end
            end
            CMD_SRE: begin
              next_cur.gear2n = 1'b0;
              next_cur.st = D_SR;
            end
            CMD_MRS_MPS: begin
              next_cur.st = D_MPENT;
              next_cur.cnt = MPED_CYC;
            end
            CMD_ACT: next_cur.window = 1'b0;
            CMD_RD: begin
              // DLL-dependent commands are refused until the lock delay has run out
              if (cur.dllCnt != CNT_ZERO) begin
                next_cur.taken = 1'b0;
                next_cur.err = 1'b1;
              end else begin
                next_cur.window = 1'b0;
              end
            end
            default: ;
          endcase
        end
      end
      D_SYNC: begin
        // count cycles since the mode command; sync must land even
        next_cur.cnt = cur.cnt + CNT_ONE;
        if (valid) begin
          if (link.cmd == CMD_NOP && !cur.cnt[0]) begin
            next_cur.st = D_SETTLE;
            next_cur.cnt = CMD_GEAR_CYC;
            next_cur.taken = 1'b1;
          end else begin
            next_cur.err = 1'b1;
          end
        end
      end
      D_SETTLE: begin
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (valid) begin
          next_cur.err = 1'b1;
        end
        if (cur.cnt == CNT_ONE) begin
          next_cur.gear2n = 1'b1;
          next_cur.st = D_RUN;
        end
      end
      D_SR: begin
        if (valid && link.cmd == CMD_SRX) begin
          next_cur.st = D_SRX;
          // one short: the edge on which the delay ends already takes a command
          next_cur.cnt = XS_CYC - CNT_ONE;
          next_cur.window = 1'b1;
          next_cur.dllCnt = XSDLL_CYC;
          next_cur.taken = 1'b1;
        end
      end
      D_SRX: begin
        // no command before the exit delay, stay 1N meanwhile
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (valid) begin
          next_cur.err = 1'b1;
        end
        if (cur.cnt == CNT_ONE) begin
          next_cur.st = D_RUN;
        end
      end
      D_MPENT: begin
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE) begin
          next_cur.st = D_MP;
        end
      end
      D_MP: begin
        // only cke and cs are looked at; cs sampled on cke rise
        if (link.cke && !cur.ckePrev && !link.csN) begin
          next_cur.st = D_MPEXIT;
          next_cur.cnt = XMP_CYC - CNT_ONE; // same end point as the exit delay above
          next_cur.dllCnt = XMP_DLL_CYC;
        end
      end
      D_MPEXIT: begin
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (valid && link.cmd != CMD_NOP) begin
          next_cur.err = 1'b1;
        end
        if (cur.cnt == CNT_ONE) begin
          next_cur.st = D_RUN;
        end
      end
      default: next_cur.st = D_RUN;
    endcase
  end
  // --------------------------------------------------
  // registers; device reset pin acts like system reset
  // --------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !link.resetN) begin
      cur.st <= D_RUN;
      cur.cnt <= CNT_ZERO;
      cur.dllCnt <= DLLK_CYC;
      cur.window <= 1'b1;
      cur.ckePrev <= 1'b0;
      cur.gear2n <= 1'b0;
      cur.taken <= 1'b0;
      cur.err <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end
  // status outputs, each straight from a flop or its decode of flops
  assign gear2n = cur.gear2n;
  assign maxPower = (cur.st == D_MP) || (cur.st == D_MPENT);
  assign selfRef = cur.st == D_SR;
  assign readyNoDll = cur.st == D_RUN;
  assign readyDll = (cur.st == D_RUN) && (cur.dllCnt == CNT_ZERO);
  assign cmdTaken = cur.taken;
  assign protoErr = cur.err;
endmodule

/* rtl/sdram_mode_ctrl.sv */
// controller end: sequences gear-down and power-save over the link
// assumes a simple register port; read data valid the cycle after rd
//
// The address map and the address-and-strobe port were chosen for this implementation.
module sdram_mode_ctrl
  import sdram_mode_pkg::*;
(
  input  wire logic        clk_sys, // system clock
  input  wire logic        sys_rst, // sync reset, high
  sdram_mode_if.ctrl       link,    // command link
  input  wire logic [3:0]  addr,    // register address
  input  wire logic [31:0] wdata,   // write data
  input  wire logic        wr,      // write strobe
  input  wire logic        rd,      // read strobe
  output logic      [31:0] rdata    // read data, cycle after rd
);
  // --------------------------------------------------
  // state
  // --------------------------------------------------
  typedef enum logic [3:0] {
    C_RESET, C_IDLE, C_GMRS, C_GSETTLE, C_SRWAIT, C_SR, C_SRX,
    C_MPHOLD, C_MP, C_MPRESTART, C_MPLOW, C_MPXMP, C_CMD
  } cstate_type;
  typedef struct packed {
    cstate_type       st;
    logic [CNT_W-1:0] cnt;     // phase counter
    logic [CNT_W-1:0] dllCnt;  // cycles until DLL commands allowed
    logic [18:0]      lat;     // latency and mode settings
    logic             window;  // gear entry allowed now
    logic             gear2n;  // device runs quarter rate
    logic             gearSrx; // enter gear after self refresh exit
    logic             cmdDll;  // pending command needs DLL
    logic             refused; // sticky: last request refused
    logic             resetN;
    logic             cke;
    logic             csN;
    logic             ckEn;
    cmd_type          cmd;
    logic [31:0]      rdata;
  } ctrl_type;
  ctrl_type cur;      // registered state
  ctrl_type next_cur; // next state
  logic     [7:0] go;      // control pulses from a write
  logic           gearOk;  // settings allow quarter rate
  logic           mpsOk;   // settings allow power-save entry
  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb begin
    next_cur = cur;
    go = (wr && addr == REG_CTRL) ? wdata[7:0] : 8'h00;
    // latencies even, additive latency legal, modes off
    gearOk = SPEED_GEAR_OK
      && !cur.lat[LB_CL] && !cur.lat[LB_CWL]
      && !cur.lat[LB_ALBAD]
      && !cur.lat[LB_CAL] && !cur.lat[LB_PAR];
    mpsOk = !cur.lat[LB_CAL] && !cur.lat[LB_PAR] && !cur.gear2n;
    if (cur.dllCnt != CNT_ZERO) begin
      next_cur.dllCnt = cur.dllCnt - CNT_ONE;
    end
    // default link drive: deselect, one-cycle cs pulses except the four-cycle NOP hold in C_MPLOW
    next_cur.csN = 1'b1;
    // register reads answer next cycle, unmapped reads zero
    next_cur.rdata = 32'h0000_0000;
    if (rd) begin
      case (addr)
        REG_LAT: next_cur.rdata = {13'h0000, cur.lat};
        REG_STATUS: next_cur.rdata = {20'h00000, cur.st, cur.refused,
          cur.dllCnt == CNT_ZERO, cur.ckEn, cur.window, cur.gear2n,
          cur.st == C_MP, cur.st == C_SR, cur.st != C_IDLE};
        default: ;
      endcase
    end
    if (wr && addr == REG_LAT) begin
      next_cur.lat = wdata[18:0];
    end
    if (go != 8'h00) begin
      next_cur.refused = 1'b0;
    end
    case (cur.st)
      C_RESET: begin
        // hold device reset, then raise cke
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE) begin
          next_cur.resetN = 1'b1;
        end
        if (cur.cnt == CNT_ZERO) begin
          next_cur.cke = 1'b1;
          next_cur.st = C_IDLE;
        end
      end
      C_IDLE: begin
        if (go[CB_GEAR]) begin
          if (cur.window && gearOk) begin
            next_cur.st = C_GMRS;
            next_cur.cnt = SYNC_GEAR_CYC;
            next_cur.cmd = CMD_MRS_GEAR;
            next_cur.csN = 1'b0;
          end else begin
            next_cur.refused = 1'b1;
          end
        end else if (go[CB_SRE]) begin
          next_cur.cmd = CMD_SRE;
          next_cur.csN = 1'b0;
          next_cur.gear2n = 1'b0;
          next_cur.st = C_SR;
        end else if (go[CB_MPSE]) begin
          if (mpsOk) begin
            next_cur.cmd = CMD_MRS_MPS;
            next_cur.csN = 1'b0;
            next_cur.cnt = CKMPE_CYC;
            next_cur.st = C_MPHOLD;
          end else begin
            next_cur.refused = 1'b1;
          end
        end else if (go[CB_CMD]) begin
          next_cur.cmdDll = go[CB_DLL];
          next_cur.st = C_CMD;
        end else if (go != 8'h00) begin
          next_cur.refused = 1'b1;
        end
      end
      C_GMRS: begin
        // command held low-frequency; sync lands an even gap later
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE) begin
          next_cur.cmd = CMD_NOP;
          next_cur.csN = 1'b0;
          next_cur.cnt = CMD_GEAR_CYC;
          next_cur.st = C_GSETTLE;
        end
      end
      C_GSETTLE: begin
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE) begin
          next_cur.gear2n = 1'b1;
          next_cur.window = 1'b0;
          next_cur.st = C_IDLE;
        end
      end
      C_SR: begin
        if (go[CB_SRX]) begin
          next_cur.cmd = CMD_SRX;
          next_cur.csN = 1'b0;
          next_cur.gearSrx = go[CB_SRXG];
          next_cur.cnt = XS_CYC;
          next_cur.dllCnt = XSDLL_CYC;
          next_cur.st = C_SRX;
        end else if (go != 8'h00) begin
          next_cur.refused = 1'b1;
        end
      end
      C_SRX: begin
        // deselect through the exit delay, then optional gear entry
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE) begin
          next_cur.window = 1'b1;
          if (cur.gearSrx && gearOk) begin
            next_cur.st = C_GMRS;
            next_cur.cnt = SYNC_GEAR_CYC;
            next_cur.cmd = CMD_MRS_GEAR;
            next_cur.csN = 1'b0;
          end else begin
            next_cur.st = C_IDLE;
          end
        end
      end
      C_MPHOLD: begin
        // clock stays valid until the hold delay, then stops
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE) begin
          next_cur.ckEn = 1'b0;
          next_cur.cke = 1'b0;
          next_cur.st = C_MP;
        end
      end
      C_MP: begin
        if (go[CB_MPSX]) begin
          next_cur.ckEn = 1'b1;
          next_cur.cnt = CKMPX_CYC;
          next_cur.st = C_MPRESTART;
        end else if (go != 8'h00) begin
          next_cur.refused = 1'b1;
        end
      end
      C_MPRESTART: begin
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE) begin
          // cs low as cke rises asks the device to leave the mode
          next_cur.cke = 1'b1;
          next_cur.csN = 1'b0;
          next_cur.cmd = CMD_NOP;
          next_cur.cnt = MPX_LH_CYC;
          next_cur.st = C_MPLOW;
        end
      end
      C_MPLOW: begin
        // NOP during the low hold, deselect afterwards
        next_cur.cnt = cur.cnt - CNT_ONE;
        next_cur.csN = 1'b0;
        if (cur.cnt == CNT_ONE) begin
          next_cur.csN = 1'b1;
          next_cur.cnt = XMP_CYC - MPX_LH_CYC;
          next_cur.dllCnt = XMP_DLL_CYC - MPX_LH_CYC;
          next_cur.st = C_MPXMP;
        end
      end
      C_MPXMP: begin
        next_cur.cnt = cur.cnt - CNT_ONE;
        if (cur.cnt == CNT_ONE) begin
          next_cur.st = C_IDLE;
        end
      end
      C_CMD: begin
        // a DLL command waits until the lock delay has run out
        if (!cur.cmdDll || cur.dllCnt == CNT_ZERO) begin
          next_cur.cmd = cur.cmdDll ? CMD_RD : CMD_ACT;
          next_cur.csN = 1'b0;
          next_cur.window = 1'b0;
          next_cur.st = C_IDLE;
        end
      end
      default: next_cur.st = C_IDLE;
    endcase
  end
  // --------------------------------------------------
  // registers
  // --------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cur.st <= C_RESET;
      cur.cnt <= RST_HOLD_CYC;
      cur.dllCnt <= DLLK_CYC;
      cur.lat <= LAT_RESET;
      cur.window <= 1'b1;
      cur.gear2n <= 1'b0;
      cur.gearSrx <= 1'b0;
      cur.cmdDll <= 1'b0;
      cur.refused <= 1'b0;
      cur.resetN <= 1'b0;
      cur.cke <= 1'b0;
      cur.csN <= 1'b1;
      cur.ckEn <= 1'b1;
      cur.cmd <= CMD_NOP;
      cur.rdata <= 32'h0000_0000;
    end else begin
      cur <= next_cur;
    end
  end
  // link and bus outputs straight from flops
  assign link.resetN = cur.resetN;
  assign link.cke = cur.cke;
  assign link.csN = cur.csN;
  assign link.ckEn = cur.ckEn;
  assign link.cmd = cur.cmd;
  assign rdata = cur.rdata;
endmodule

/* verification/sdram_geardown_and_power_save_checker.sv */
// checker for the gear-down / power-save link between the two ends
// assumes one clock domain; device status outputs are watched beside the link
module sdram_geardown_and_power_save_checker
  import sdram_mode_pkg::*;
(
  input wire logic clk_sys,    // system clock
  input wire logic sys_rst,    // sync reset, high
  input wire logic resetN,     // device reset on the link
  input wire logic cke,        // clock enable on the link
  input wire logic csN,        // chip select on the link
  input wire logic ckEn,       // memory clock valid
  input cmd_type   cmd,        // command code
  input wire logic gear2n,     // device in 2N
  input wire logic maxPower,   // device in power-save
  input wire logic selfRef,    // device in self refresh
  input wire logic readyNoDll, // plain commands accepted
  input wire logic readyDll,   // dll commands accepted
  input wire logic cmdTaken,   // command accepted pulse
  input wire logic protoErr    // illegal command pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  logic cmdOn; // a selected command this cycle
  assign cmdOn = cke && !csN;
  // --------------------------------------------------
  // properties
  // --------------------------------------------------
  property p_boot_1n; $fell(sys_rst) |-> !gear2n; endproperty
  a_boot_1n: assert property (p_boot_1n)
    else $error("device left reset in 2N");
  // sync pulse exactly eight cycles after the gear command, seven quiet cycles between
  property p_sync_gap;
    (cmdOn && cmd == CMD_MRS_GEAR) |=> csN[*7] ##1 (!csN && cmd == CMD_NOP);
  endproperty
  a_sync_gap: assert property (p_sync_gap)
    else $error("sync pulse not at even gap");
  property p_gear_on;
    (cmdOn && cmd == CMD_MRS_GEAR) |-> ##10 !gear2n[*5] ##[1:4] gear2n;
  endproperty
  a_gear_on: assert property (p_gear_on)
    else $error("2N not reached after gear delay");
  property p_sre_1n; (cmdOn && cmd == CMD_SRE) |-> ##[1:2] (!gear2n && selfRef); endproperty
  a_sre_1n: assert property (p_sre_1n)
    else $error("self refresh kept 2N");
  property p_srx_wait; (cmdOn && cmd == CMD_SRX) |=> !readyNoDll[*8]; endproperty
  a_srx_wait: assert property (p_srx_wait)
    else $error("ready too soon after self refresh exit");
  // 2N only drops through self refresh or device reset
  property p_leave_2n;
    $fell(gear2n) |-> (selfRef || $past(selfRef) || !resetN || !$past(resetN));
  endproperty
  a_leave_2n: assert property (p_leave_2n)
    else $error("2N left outside self refresh");
  property p_ps_ignore;
    (maxPower && $past(maxPower) && $past(cke) && cmdOn) |=> !cmdTaken;
  endproperty
  a_ps_ignore: assert property (p_ps_ignore)
    else $error("command taken in power-save");
  property p_ps_entry; (cmdOn && cmd == CMD_MRS_MPS && readyNoDll) |-> ##[1:2] maxPower; endproperty
  a_ps_entry: assert property (p_ps_entry)
    else $error("power-save not entered");
  property p_ps_exit; ($rose(cke) && !csN && maxPower) |-> ##[1:2] !maxPower; endproperty
  a_ps_exit: assert property (p_ps_exit)
    else $error("power-save not left on cke rise");
  property p_exit_nop;
    ($rose(cke) && !csN && cmd == CMD_NOP) |-> (!csN && cmd == CMD_NOP)[*4] ##1 csN[*8];
  endproperty
  a_exit_nop: assert property (p_exit_nop)
    else $error("exit not nop then deselect");
  property p_answer;
    (readyNoDll && !maxPower && cmdOn) |=> (cmdTaken ^ protoErr);
  endproperty
  a_answer: assert property (p_answer)
    else $error("command not answered next cycle");
endmodule

/* verification/sdram_geardown_and_power_save_test.sv */
// self-checking bench: controller and device joined over the link
// assumes the register map and delays of sdram_mode_pkg
module sdram_geardown_and_power_save_test
  import sdram_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys;        // 250 MHz clock
  logic        sys_rst;        // sync reset
  logic [3:0]  addr;           // register address
  logic [31:0] wdata;          // write data
  logic        wr;             // write strobe
  logic        rd;             // read strobe
  logic [31:0] rdata;          // read data
  logic        gear2n;         // device status outputs
  logic        maxPower;
  logic        selfRef;
  logic        readyNoDll;
  logic        readyDll;
  logic        cmdTaken;
  logic        protoErr;
  int          errors = 0;     // mismatches
  int          checks = 0;     // comparisons
  int          cycleCount = 0; // hang guard
  int          takenCount = 0; // accepted commands
  int          base;           // count snapshot
  logic [31:0] rnd;            // lfsr state
  logic [31:0] rv;             // read value
  logic [31:0] lat;            // latency setting
  logic [18:0] latTab [6];     // illegal settings, last one clean
  // --------------------------------------------------
  // clock, link and ends
  // --------------------------------------------------
  initial clk_sys = 1'h0;
  always #2 clk_sys = ~clk_sys;
  sdram_mode_if link ();
  sdram_mode_ctrl u_sdram_mode_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  sdram_mode_dev u_sdram_mode_dev (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
    .gear2n(gear2n), .maxPower(maxPower), .selfRef(selfRef), .readyNoDll(readyNoDll),
    .readyDll(readyDll), .cmdTaken(cmdTaken), .protoErr(protoErr));
  sdram_geardown_and_power_save_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .resetN(link.resetN), .cke(link.cke), .csN(link.csN), .ckEn(link.ckEn), .cmd(link.cmd),
    .gear2n(gear2n), .maxPower(maxPower), .selfRef(selfRef), .readyNoDll(readyNoDll),
    .readyDll(readyDll), .cmdTaken(cmdTaken), .protoErr(protoErr));
  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // gear entry legal only with even latencies and no extra modes
  function automatic logic gear_ok(input logic [18:0] l);
    return SPEED_GEAR_OK && !l[0] && !l[8] && l[18:16] == 3'h0;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk_sys);
    wr <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk_sys);
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  // poll status until masked bits match, bounded
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    rd_reg(REG_STATUS, rv);
    while ((rv & m) !== v && n < 3000) begin
      rd_reg(REG_STATUS, rv);
      n++;
    end
    check(rv & m, v);
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (!(readyNoDll && readyDll) && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    check(32'({readyNoDll, readyDll}), 32'h3);
  endtask
  // --------------------------------------------------
  // monitors: accepted commands, no illegal ones, hang guard
  // --------------------------------------------------
  always @(posedge clk_sys) begin
    if (cmdTaken === 1'h1) takenCount <= takenCount + 1;
    if (!sys_rst) check(32'(protoErr), 32'h0);
    cycleCount++;
    if (cycleCount == 60000) begin
      errors++;
      $display("CHECK FAILED %0t run too long", $time);
      stop_test();
    end
  end
  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    sys_rst = 1'h1;
    addr    = 4'h0;
    wdata   = 32'h0;
    wr      = 1'h0;
    rd      = 1'h0;
    rnd     = 32'hCB484083;
    latTab  = '{19'h00001, 19'h00100, 19'h10000, 19'h20000, 19'h40000, 19'h00000};
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'h0;
    wait_stat(32'h1, 32'h0);
    check(32'(gear2n), 32'h0);
    rd_reg(4'hC, rv);
    check(rv, 32'h0);
    rd_reg(REG_CTRL, rv);
    check(rv, 32'h0);
    // each illegal setting refuses gear entry; the clean one enters 2N
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      lat = {13'h0, latTab[i]} | (rnd & 32'h00001E1E);
      wr_reg(REG_LAT, lat);
      rd_reg(REG_LAT, rv);
      check(rv, lat);
      wr_reg(REG_CTRL, 32'h1);
      wait_stat(32'h1, 32'h0);
      check(32'(rv[7]), 32'(!gear_ok(lat[18:0])));
      check(32'(gear2n), 32'(gear_ok(lat[18:0])));
    end
    // power-save must be refused while 2N is on
    wr_reg(REG_CTRL, 32'h10);
    wait_stat(32'h1, 32'h0);
    check(rv & 32'h84, 32'h80);
    // self refresh drops 2N; exit once with gear, once staying 1N
    for (int g = 1; g >= 0; g--) begin
      wait_ready();
      wr_reg(REG_CTRL, 32'h2);
      wait_stat(32'h2, 32'h2);
      check(32'({selfRef, gear2n}), 32'h2);
      wr_reg(REG_CTRL, 32'h4 | (g << 3));
      wait_stat(32'h3, 32'h0);
      wait_ready();
      check(32'({selfRef, gear2n}), 32'(g));
    end
    // random mix of plain and dll commands, one acceptance each
    base = takenCount;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wr_reg(REG_CTRL, 32'h40 | (rnd & 32'h80));
      wait_stat(32'h1, 32'h0);
    end
    // the last acceptance pulse is counted on a later edge
    repeat (2) @(posedge clk_sys);
    check(takenCount - base, 32'h8);
    // power-save: commands ignored, exit restores readiness
    wr_reg(REG_CTRL, 32'h10);
    wait_stat(32'h4, 32'h4);
    check(32'(rv[5]), 32'h0);
    check(32'(maxPower), 32'h1);
    base = takenCount;
    wr_reg(REG_CTRL, 32'h40);
    repeat (64) @(posedge clk_sys);
    check(takenCount - base, 32'h0);
    wr_reg(REG_CTRL, 32'h20);
    wait_stat(32'h5, 32'h0);
    check(32'(rv[5]), 32'h1);
    wait_ready();
    check(32'(maxPower), 32'h0);
    wr_reg(REG_CTRL, 32'hC0);
    wait_stat(32'h1, 32'h0);
    repeat (2) @(posedge clk_sys);
    check(takenCount - base, 32'h1);
    stop_test();
  end
endmodule
